// *** msr_pkg.sv ***
// constants, field layout and state codes for the mode/sequencer register bank
// assumes a 32-bit avalon-mm slave where register index n sits at byte 4*n
package msr_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [5:0] MSR_IDX_SEQ_STATUS = 6'h04;
   localparam logic [5:0] MSR_IDX_OPMODE = 6'h1c;
   localparam logic [5:0] MSR_IDX_MODE_STATUS = 6'h1d;
   localparam logic [5:0] MSR_IDX_LAUNCH = 6'h1e;
   localparam logic [5:0] MSR_IDX_CANCEL = 6'h1f;
   localparam logic [5:0] MSR_IDX_SCAN_EN = 6'h20;
   localparam logic [5:0] MSR_IDX_PIN_CFG = 6'h24;
   localparam int unsigned MSR_IDX_LSB = 2;

   // ----------------------------------------------------------------
   // reset values and field layout
   // ----------------------------------------------------------------
   localparam logic [2:0] MSR_OPMODE_RST = 3'h0;
   localparam logic [1:0] MSR_SCAN_EN_RST = 2'h3;
   localparam logic [1:0] MSR_PIN_CFG_RST = 2'h0;
   localparam logic [31:0] MSR_ZERO_WORD = 32'h0000_0000;
   localparam int unsigned MSR_STROBE_BIT = 0;
   localparam int unsigned MSR_HS_BIT = 2;
   localparam int unsigned MSR_ERR_LSB = 1;
   localparam int unsigned MSR_LOOP_BIT = 1;
   localparam int unsigned MSR_AUTO_BIT = 2;
   localparam logic [2:0] MSR_MODE_AUTON = 3'h6;
   localparam logic [2:0] MSR_MODE_HIPREC = 3'h7;

   // ----------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      MSR_ACT_MANUAL = 2'h0,
      MSR_ACT_AUTON = 2'h2,
      MSR_ACT_HIPREC = 2'h3
   } msr_act_type;

   typedef enum logic [1:0]
   {
      MSR_ERR_OFF = 2'h0,
      MSR_ERR_RUN = 2'h1,
      MSR_ERR_FAULT = 2'h3
   } msr_err_type;

   typedef enum logic [1:0]
   {
      MSR_ST_IDLE = 2'h0,
      MSR_ST_CONV = 2'h1
   } msr_state_type;

endpackage

// *** msr_sync3.sv ***
// three-stage synchroniser for asynchronous level inputs
// assumes the output is only read in the CLK_I domain
`timescale 1ns/1ns
`default_nettype none
module msr_sync3
   import msr_pkg::*;
#(
   parameter int unsigned WIDTH = 1
)
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // level in and filtered level out
   input wire logic [WIDTH-1:0] D_I,
   output logic [WIDTH-1:0] Q_O
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // first stage feeds only the second one
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= D_I;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         Q_O <= '0;
      else
      begin
         for (int i = 0; i < WIDTH; i++)
         begin
            if (s2_q[i] == s3_q[i])
               Q_O[i] <= s3_q[i];
         end
      end
   end

endmodule
`default_nettype wire

// *** msr_regs.sv ***
// mode select, mode status, pin config and scan sequencer registers
// assumes an avalon-mm master with waitrequest and a conversion
// datapath on the same clock that pulses CONV_DONE_I per conversion
//
// Overview of operation
// - mode code 000/001 manual ch0, 10x manual scan, 110 autonomous, 111 precision.
// - upper five bits of the mode select register read zero, read-only.
// - status bit 2 reads one while the host link runs high speed.
// - active mode reads 00 manual, 10 autonomous, 11 precision, never 01.
// - pin arrangement field: 00/11 dual, 01 ground sense, 10 pseudo-differential.
// - mask bit 1 includes channel 1, bit 0 includes channel 0.
// - scan channel enable resets to 0x03.
// - writing launch bit raises busy and starts first scan conversion, except in a 1xx mode with an empty mask.
// - write to cancel register at 0x1f ends scanning in progress.
// - cancel bit stops current conversion and drops busy.
// - scan error state clears to 00 on launch and reset.
`timescale 1ns/1ns
`default_nettype none
module msr_regs
   import msr_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // avalon-mm slave
   input wire logic [7:0] ADDRESS_I,
   input wire logic READ_I,
   input wire logic WRITE_I,
   input wire logic [31:0] WRITEDATA_I,
   input wire logic [3:0] BYTEENABLE_I,
   output logic [31:0] READDATA_O,
   output logic WAITREQUEST_O,
   // host link speed state, asynchronous
   input wire logic HS_LINK_I,
   // conversion datapath handshake
   input wire logic CONV_DONE_I,
   output logic CONV_START_O,
   output logic CONV_ABORT_O,
   output logic CH_SEL_O,
   output logic BUSY_O,
   // configuration to the datapath
   output logic [2:0] OP_MODE_O,
   output logic [1:0] ACTIVE_MODE_O,
   output logic [1:0] INPUT_ARRANGE_O,
   output logic [1:0] SCAN_MASK_O
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic msr_act_type decode_active(input logic [2:0] m);
      msr_act_type a;
      a = MSR_ACT_MANUAL;
      if (m == MSR_MODE_AUTON)
         a = MSR_ACT_AUTON;
      else if (m == MSR_MODE_HIPREC)
         a = MSR_ACT_HIPREC;
      return a;
   endfunction

   function automatic logic first_channel(input logic [1:0] mask);
      return ~mask[0];
   endfunction

   // ----------------------------------------------------------------
   // bus handshake: one wait state per access
   // ----------------------------------------------------------------
   logic ack_q;
   logic [5:0] idx;
   logic wr_fire;
   logic launch;
   logic cancel;
   logic launch_q;
   logic hs_flag;
   logic [2:0] opmode_q;
   logic [1:0] mask_q;
   logic [1:0] pincfg_q;
   msr_act_type act_q;
   msr_err_type err_q;
   msr_state_type state_q;
   logic ch_q;
   logic busy_q;
   logic start_q;
   logic abort_q;
   logic [31:0] rdata_q;

   assign idx = ADDRESS_I[MSR_IDX_LSB +: 6];
   assign WAITREQUEST_O = (READ_I | WRITE_I) & ~ack_q;
   assign wr_fire = WRITE_I & ack_q & BYTEENABLE_I[0];
   // pulses only, nothing is kept
   assign launch = wr_fire && idx == MSR_IDX_LAUNCH && WRITEDATA_I[MSR_STROBE_BIT];
   assign cancel = wr_fire && idx == MSR_IDX_CANCEL && WRITEDATA_I[MSR_STROBE_BIT];

   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         ack_q <= 1'b0;
      else
         ack_q <= (READ_I | WRITE_I) & ~ack_q;
   end

   msr_sync3 #(.WIDTH(1)) u_hs_sync
   (
      .CLK_I(CLK_I),
      .RESET_I(RESET_I),
      .D_I(HS_LINK_I),
      .Q_O(hs_flag)
   );

   // ----------------------------------------------------------------
   // writable registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         opmode_q <= MSR_OPMODE_RST;
         mask_q <= MSR_SCAN_EN_RST;
         pincfg_q <= MSR_PIN_CFG_RST;
      end
      else if (wr_fire)
      begin
         if (idx == MSR_IDX_OPMODE)
            opmode_q <= WRITEDATA_I[2:0];
         if (idx == MSR_IDX_SCAN_EN)
            mask_q <= WRITEDATA_I[1:0];
         if (idx == MSR_IDX_PIN_CFG)
            pincfg_q <= WRITEDATA_I[1:0];
      end
   end

   // reserved codes 010/011 fall into manual decoding
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         act_q <= MSR_ACT_MANUAL;
      else
         act_q <= decode_active(opmode_q);
   end

   // ----------------------------------------------------------------
   // read data, loaded in the wait cycle
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         rdata_q <= MSR_ZERO_WORD;
      else if (READ_I & ~ack_q)
      begin
         rdata_q <= MSR_ZERO_WORD;
         case (idx)
            MSR_IDX_OPMODE: rdata_q[2:0] <= opmode_q;
            MSR_IDX_MODE_STATUS:
            begin
               rdata_q[MSR_HS_BIT] <= hs_flag;
               rdata_q[1:0] <= act_q;
            end
            MSR_IDX_SCAN_EN: rdata_q[1:0] <= mask_q;
            MSR_IDX_PIN_CFG: rdata_q[1:0] <= pincfg_q;
            MSR_IDX_SEQ_STATUS: rdata_q[MSR_ERR_LSB +: 2] <= err_q;
            default: rdata_q <= MSR_ZERO_WORD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // scan sequencer
   // ----------------------------------------------------------------
   // cancel outranks a launch in the same cycle
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         state_q <= MSR_ST_IDLE;
         ch_q <= 1'b0;
         busy_q <= 1'b0;
         start_q <= 1'b0;
      end
      else
      begin
         start_q <= 1'b0;
         if (cancel)
         begin
            state_q <= MSR_ST_IDLE;
            busy_q <= 1'b0;
         end
         else if (launch)
         begin
            if (!opmode_q[MSR_AUTO_BIT])
            begin
               ch_q <= 1'b0;
               state_q <= MSR_ST_CONV;
               busy_q <= 1'b1;
               start_q <= 1'b1;
            end
            else if (mask_q != 2'h0)
            begin
               ch_q <= first_channel(mask_q);
               state_q <= MSR_ST_CONV;
               busy_q <= 1'b1;
               start_q <= 1'b1;
            end
         end
         else
         begin
            case (state_q)
               MSR_ST_IDLE: busy_q <= 1'b0;
               MSR_ST_CONV:
               begin
                  if (CONV_DONE_I)
                  begin
                     if (opmode_q[MSR_AUTO_BIT] && !ch_q && mask_q[1])
                     begin
                        ch_q <= 1'b1;
                        start_q <= 1'b1;
                     end
                     else if (opmode_q[MSR_AUTO_BIT] && opmode_q[MSR_LOOP_BIT])
                     begin
                        // autonomous and precision modes rescan until cancelled
                        ch_q <= first_channel(mask_q);
                        start_q <= 1'b1;
                     end
                     else
                     begin
                        state_q <= MSR_ST_IDLE;
                        busy_q <= 1'b0;
                     end
                  end
               end
               default:
               begin
                  state_q <= MSR_ST_IDLE;
                  busy_q <= 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         abort_q <= 1'b0;
      else
         abort_q <= cancel && state_q == MSR_ST_CONV;
   end

   // remembers a launch for one cycle so an empty-mask launch can flag a fault
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         launch_q <= 1'b0;
      else
         launch_q <= launch;
   end

   // launch clears first; the new state shows one cycle later
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         err_q <= MSR_ERR_OFF;
      else if (launch)
         err_q <= MSR_ERR_OFF;
      else if (busy_q && opmode_q[MSR_AUTO_BIT])
         err_q <= MSR_ERR_RUN;
      else if (launch_q && opmode_q[MSR_AUTO_BIT] && mask_q == 2'h0)
         err_q <= MSR_ERR_FAULT;
      else if (!busy_q && err_q == MSR_ERR_RUN)
         err_q <= MSR_ERR_OFF;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign READDATA_O = rdata_q;
   assign CONV_START_O = start_q;
   assign CONV_ABORT_O = abort_q;
   assign CH_SEL_O = ch_q;
   assign BUSY_O = busy_q;
   assign OP_MODE_O = opmode_q;
   assign ACTIVE_MODE_O = act_q;
   assign INPUT_ARRANGE_O = pincfg_q;
   assign SCAN_MASK_O = mask_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RESET_I);

   sequence s_launch_write;
      WRITE_I && !WAITREQUEST_O && BYTEENABLE_I[0] && idx == MSR_IDX_LAUNCH
         && WRITEDATA_I[MSR_STROBE_BIT] && !cancel;
   endsequence

   sequence s_scan_begun;
      BUSY_O && CONV_START_O;
   endsequence

   AST_AUTON_DECODE: assert property (OP_MODE_O == MSR_MODE_AUTON |=> ACTIVE_MODE_O == MSR_ACT_AUTON)
      else $error("autonomous code not reported as autonomous");
   AST_NEVER_01: assert property (ACTIVE_MODE_O != 2'h1)
      else $error("active mode reported unused code");
   AST_OPMODE_UPPER_ZERO: assert property (READ_I && !WAITREQUEST_O && idx == MSR_IDX_OPMODE
      |-> READDATA_O[31:3] == 29'h0 && READDATA_O[2:0] == OP_MODE_O)
      else $error("mode select readback wrong");
   AST_HS_READBACK: assert property (READ_I && !WAITREQUEST_O && idx == MSR_IDX_MODE_STATUS
      |-> READDATA_O[MSR_HS_BIT] == $past(hs_flag))
      else $error("high speed flag readback wrong");
   AST_LAUNCH_BUSY: assert property (s_launch_write ##0 (!OP_MODE_O[MSR_AUTO_BIT] || SCAN_MASK_O != 2'h0)
      |=> s_scan_begun)
      else $error("launch did not raise busy and start conversion");
   AST_CANCEL_STOPS: assert property (cancel |=> (!BUSY_O && state_q == MSR_ST_IDLE) [*2])
      else $error("cancel did not end the scan");
   AST_CANCEL_PULSE: assert property (cancel && state_q == MSR_ST_CONV |=> CONV_ABORT_O ##1 !CONV_ABORT_O)
      else $error("abort pulse missing");
   AST_ERR_CLEAR: assert property (launch |=> err_q == MSR_ERR_OFF)
      else $error("error state not cleared on launch");
   AST_STROBE_READ_ZERO: assert property (READ_I && !WAITREQUEST_O
      && (idx == MSR_IDX_LAUNCH || idx == MSR_IDX_CANCEL) |-> READDATA_O == MSR_ZERO_WORD)
      else $error("strobe register read non-zero");
   AST_CHANNEL_ALLOWED: assert property (CONV_START_O |-> (!OP_MODE_O[MSR_AUTO_BIT] && !CH_SEL_O)
      || (OP_MODE_O[MSR_AUTO_BIT] && SCAN_MASK_O[CH_SEL_O]))
      else $error("conversion on excluded channel");
   AST_PIN_CFG: assert property (wr_fire && idx == MSR_IDX_PIN_CFG |=> INPUT_ARRANGE_O == $past(WRITEDATA_I[1:0]))
      else $error("pin arrangement not updated");

endmodule
`default_nettype wire

// *** msr_conv_model.sv ***
// behavioural conversion datapath: answers each start pulse with a done pulse unless aborted first
// assumes the register bank's clock and reset; latency chosen by the bench
`timescale 1ns/1ns
`default_nettype none
module msr_conv_model
   import msr_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // handshake with the register bank
   input wire logic [3:0] LAT_I,
   input wire logic START_I,
   input wire logic ABORT_I,
   output logic DONE_O
);
   logic [3:0] cnt_q;
   logic run_q;

   // abort kills the conversion so no late done leaks into the next scan
   always_ff @(posedge CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         run_q <= 1'b0;
         cnt_q <= 4'h0;
         DONE_O <= 1'b0;
      end
      else
      begin
         DONE_O <= 1'b0;
         if (START_I)
         begin
            run_q <= 1'b1;
            cnt_q <= 4'h0;
         end
         else if (ABORT_I)
            run_q <= 1'b0;
         else if (run_q)
         begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == LAT_I)
            begin
               run_q <= 1'b0;
               DONE_O <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the mode and scan register bank
// assumes msr_pkg, msr_regs and msr_conv_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
   import msr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] address = 8'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'h1;
   logic hs = 1'b0;
   logic [3:0] lat = 4'h1;
   logic [31:0] rdata, q;
   logic wreq, done, start, abort, chsel, busy;
   logic [2:0] opm;
   logic [1:0] act, arr, mask;
   logic chs[$];
   logic [2:0] modes[6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
   logic [1:0] acts[6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3};
   int err_total = 0;
   int compares = 0;

   msr_regs dut
   (
      .CLK_I(clk), .RESET_I(rst), .ADDRESS_I(address), .READ_I(rd_en), .WRITE_I(wr_en),
      .WRITEDATA_I(wdata), .BYTEENABLE_I(be), .READDATA_O(rdata), .WAITREQUEST_O(wreq),
      .HS_LINK_I(hs), .CONV_DONE_I(done), .CONV_START_O(start), .CONV_ABORT_O(abort),
      .CH_SEL_O(chsel), .BUSY_O(busy), .OP_MODE_O(opm), .ACTIVE_MODE_O(act),
      .INPUT_ARRANGE_O(arr), .SCAN_MASK_O(mask)
   );

   msr_conv_model dpath
   (
      .CLK_I(clk), .RESET_I(rst), .LAT_I(lat), .START_I(start), .ABORT_I(abort), .DONE_O(done)
   );

   initial
   begin
      forever #25 clk = ~clk;
   end

   // channel of every conversion the bank launches
   always @(posedge clk)
   begin
      if (start === 1'b1)
         chs.push_back(chsel);
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one edge first, so a release and the next request never share a time step
   task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= {idx, 2'b00};
      wdata <= d;
      wr_en <= w;
      rd_en <= !w;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wreq !== 1'b0 && n < 20);
      if (n >= 20)
         chk("waitrequest", 32'h0, 32'h1);
      q = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input string nm);
      bus(1'b0, idx, 32'h0);
      chk(nm, exp, q);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      chk("busy_idle", 32'h0, busy);
   endtask

   task automatic launch(input logic [2:0] m, input logic [1:0] msk);
      bus(1'b1, MSR_IDX_OPMODE, {29'h0, m});
      bus(1'b1, MSR_IDX_SCAN_EN, {30'h0, msk});
      chs.delete();
      bus(1'b1, MSR_IDX_LAUNCH, 32'h1);
      @(posedge clk);
   endtask

   task automatic scan(input logic [2:0] m, input logic [1:0] msk, input int n, input logic [1:0] ord);
      launch(m, msk);
      chk("busy", 32'h1, busy);
      wait_idle();
      chk("starts", n, chs.size());
      foreach (chs[i]) chk("channel", ord[i], chs[i]);
   endtask

   task automatic results();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      results();
   end

   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      // ------------------------------------------------------------
      // reset values
      // ------------------------------------------------------------
      chk("scan_mask_o", 32'h3, mask);
      rd(MSR_IDX_OPMODE, 32'h0, "opmode");
      rd(MSR_IDX_MODE_STATUS, 32'h0, "mode_status");
      rd(MSR_IDX_SCAN_EN, 32'h3, "scan_en");
      rd(MSR_IDX_PIN_CFG, 32'h0, "pin_cfg");
      rd(MSR_IDX_SEQ_STATUS, 32'h0, "seq_status");
      // ------------------------------------------------------------
      // mode codes, pin arrangement, link speed flag
      // ------------------------------------------------------------
      foreach (modes[i])
      begin
         bus(1'b1, MSR_IDX_OPMODE, {29'h1fffffff, modes[i]});
         rd(MSR_IDX_OPMODE, {29'h0, modes[i]}, "opmode");
         chk("op_mode_o", modes[i], opm);
         rd(MSR_IDX_MODE_STATUS, {30'h0, acts[i]}, "active_mode");
         chk("active_mode_o", acts[i], act);
      end
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, MSR_IDX_PIN_CFG, 32'hfc | i);
         rd(MSR_IDX_PIN_CFG, i, "pin_cfg");
         chk("input_arrange_o", i, arr);
      end
      hs <= 1'b1;
      repeat (5) @(posedge clk);
      rd(MSR_IDX_MODE_STATUS, 32'h7, "mode_status");
      hs <= 1'b0;
      repeat (5) @(posedge clk);
      rd(MSR_IDX_MODE_STATUS, 32'h3, "mode_status");
      // unmapped place and disabled byte lane leave state alone
      bus(1'b1, 6'h3a, 32'hff);
      rd(6'h3a, 32'h0, "unmapped");
      be <= 4'h0;
      bus(1'b1, MSR_IDX_PIN_CFG, 32'h1);
      be <= 4'h1;
      rd(MSR_IDX_PIN_CFG, 32'h3, "pin_cfg");
      // ------------------------------------------------------------
      // scans, fast and slow datapath
      // ------------------------------------------------------------
      scan(3'h1, 2'h2, 1, 2'b00);
      scan(3'h4, 2'h3, 2, 2'b10);
      scan(3'h5, 2'h2, 1, 2'b01);
      lat <= 4'h6;
      scan(3'h4, 2'h1, 1, 2'b00);
      rd(MSR_IDX_LAUNCH, 32'h0, "launch_reg");
      rd(MSR_IDX_CANCEL, 32'h0, "cancel_reg");
      lat <= 4'h8;
      launch(MSR_MODE_HIPREC, 2'h3);
      chk("busy", 32'h1, busy);
      bus(1'b1, MSR_IDX_CANCEL, 32'h1);
      @(posedge clk);
      chk("busy", 32'h0, busy);
      chk("abort", 32'h1, abort);
      // empty mask in auto mode sets the error, next launch clears it
      launch(MSR_MODE_AUTON, 2'h0);
      chk("busy", 32'h0, busy);
      rd(MSR_IDX_SEQ_STATUS, 32'h6, "seq_status");
      launch(MSR_MODE_AUTON, 2'h3);
      rd(MSR_IDX_SEQ_STATUS, 32'h2, "seq_status");
      bus(1'b1, MSR_IDX_CANCEL, 32'h1);
      @(posedge clk);
      chk("busy", 32'h0, busy);
      rd(MSR_IDX_SEQ_STATUS, 32'h0, "seq_status");
      results();
   end
endmodule
`default_nettype wire
